// ---- hbps_pkg.sv ----
`default_nettype none
package hbps_pkg;
   // ------------------------------------------------------------
   // Soft-start counter and oscillator ramp
   // ------------------------------------------------------------
   localparam int SS_W = 12;
   localparam int RAMP_W = 8;
   localparam logic [SS_W-1:0] SS_RESET = 12'h000;
   localparam logic [SS_W-1:0] SS_MAX = 12'hfff;
   // Level equivalent of 250 mV / 0.25 V restart point
   localparam logic [SS_W-1:0] SS_RESTART_LVL = 12'h04d;
   // Level giving a 42 % duty point
   localparam logic [SS_W-1:0] SS_DUTY42_LVL = 12'h6b8;
   // Mild fault fast discharge stops at 0.85 of entry value
   localparam int MILD_NUM = 17;
   localparam int MILD_DEN = 20;
   // Default step sizes per oscillator cycle, slow discharge per mclk in hiccup
   localparam logic [SS_W-1:0] STEP_CHARGE_DEF = 12'h010;
   localparam logic [SS_W-1:0] STEP_FAST_DIS_DEF = 12'h010;
   localparam logic [SS_W-1:0] STEP_SLOW_DIS_DEF = 12'h001;
   // Oscillator cycle length in mclk cycles (fixed 500 kHz)
   localparam int OSC_FREQ_KHZ = 500;
   localparam int MCLK_FREQ_KHZ = 125000;
   localparam int OSC_CYCLES = MCLK_FREQ_KHZ / OSC_FREQ_KHZ;
   localparam logic [RAMP_W-1:0] OSC_LAST = 8'(OSC_CYCLES - 1);
   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      HBPS_OFF = 3'b000,
      HBPS_SOFT = 3'b001,
      HBPS_RUN = 3'b011,
      HBPS_MILD = 3'b010,
      HBPS_HICCUP = 3'b110,
      HBPS_WAIT = 3'b111
   } hbps_state_t;
endpackage
`default_nettype wire

// ---- hbps_osc.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbps_osc
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Run control
   input wire logic run,
   // Ramp and phase
   output logic [hbps_pkg::RAMP_W-1:0] ramp_r,
   output logic high_phase_r,
   output logic cycle_end
);
   // ------------------------------------------------------------
   // Sawtooth and phase
   // ------------------------------------------------------------
   assign cycle_end = (ramp_r == hbps_pkg::OSC_LAST);

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         ramp_r <= '0;
      else if (!run || cycle_end)
         ramp_r <= '0;
      else
         ramp_r <= ramp_r + 8'h01;
   end

   // Held in low phase while idle so restart opens on the low side
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         high_phase_r <= 1'b0;
      else if (!run)
         high_phase_r <= 1'b0;
      else if (cycle_end)
         high_phase_r <= ~high_phase_r;
   end
endmodule
`default_nettype wire

// ---- hbps_top.sv ----
// Notes on behaviour
// - Low side drives first; each output pulses once per two osc cycles.
// - Period is a low-side cycle followed by a high-side cycle.
// - Low drive only in low cycle, high drive only in high cycle.
// - In soft start, pulse ends when ramp passes soft-start level.
// - Once soft-start reaches dead-band reference, that reference ends pulses.
// - Soft-start level ramps up at charge rate after every restart, from zero only at first start.
// - Supply-good rising starts a soft-start cycle.
// - Supply loss stops switching on the next clock edge.
// - After soft start completes, level is held at its final value.
// - Moderate overcurrent ignored until a soft start completes.
// - Overcurrent in low cycle discharges level until next low cycle.
// - Under moderate overcurrent, max duty falls from 47 to 42 percent.
// - Below the 42 percent point a hiccup starts, both outputs low.
// - Hiccup discharges slowly to restart level, then recharge resumes.
// - After hiccup, switching resumes through a full soft start.
// - Severe overcurrent kills outputs at once, then hiccup and soft start.
// - Severe overcurrent response is active at all times.
// - Five faults each start a hiccup-and-retry cycle.
// - Mild fault: fast discharge to 0.85 of level, then slow discharge.
// - After soft start, duty set by dead-band against feed-forward peak.
// - Undervoltage shuts down; restart needs restart level and supply back.
// - Overtemperature shuts down; restart needs discharge and cool-down.
// - Input detect low keeps outputs static; high enables switching.
`timescale 1ns/1ps
`default_nettype none
module hbps_top
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Supply, enable and fault comparators
   input wire logic supply_good,
   input wire logic input_detect_level,
   input wire logic moderate_overcurrent,
   input wire logic severe_overcurrent,
   input wire logic overtemp,
   input wire logic mild_fault,
   // Analog levels as codes
   input wire logic [hbps_pkg::RAMP_W-1:0] dead_band_reference,
   input wire logic [hbps_pkg::RAMP_W-1:0] ff_peak,
   // Soft-start step sizes
   input wire logic [hbps_pkg::SS_W-1:0] step_charge,
   input wire logic [hbps_pkg::SS_W-1:0] step_fast_dis,
   input wire logic [hbps_pkg::SS_W-1:0] step_slow_dis,
   // Gate drives
   output logic low_side_drive,
   output logic high_side_drive,
   // Status
   output logic [2:0] seq_state,
   output logic [hbps_pkg::SS_W-1:0] ss_level,
   output logic ss_done,
   output logic oc_armed,
   output logic hiccup_active
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   hbps_pkg::hbps_state_t state_r;
   hbps_pkg::hbps_state_t state_nxt;
   logic [hbps_pkg::SS_W-1:0] ss_r;
   logic [hbps_pkg::SS_W-1:0] ss_nxt;
   logic [hbps_pkg::SS_W-1:0] mild_floor_r;
   logic oc_armed_r;
   logic oc_hit_r;
   logic oc_latched_r;
   logic low_seen_r;
   logic [15:0] db_quot;
   logic ss_done_r;
   logic low_q_r;
   logic high_q_r;
   logic [hbps_pkg::RAMP_W-1:0] ramp;
   logic high_phase;
   logic cycle_end;
   logic run;
   logic hard_fault;
   logic supply_ok;
   logic restart_ok;
   logic [hbps_pkg::RAMP_W-1:0] limit;
   logic [hbps_pkg::RAMP_W-1:0] db_scaled;
   logic [hbps_pkg::RAMP_W-1:0] ss_ramp;
   logic [hbps_pkg::RAMP_W-1:0] cap42;
   logic pulse_on;
   logic cycle_start;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [hbps_pkg::SS_W-1:0] sat_add(
      input logic [hbps_pkg::SS_W-1:0] a,
      input logic [hbps_pkg::SS_W-1:0] b);
      logic [hbps_pkg::SS_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[hbps_pkg::SS_W] ? hbps_pkg::SS_MAX : s[hbps_pkg::SS_W-1:0];
   endfunction

   function automatic logic [hbps_pkg::SS_W-1:0] sat_sub(
      input logic [hbps_pkg::SS_W-1:0] a,
      input logic [hbps_pkg::SS_W-1:0] b);
      sat_sub = (a > b) ? a - b : hbps_pkg::SS_RESET;
   endfunction

   // Soft-start code scaled onto the ramp range
   function automatic logic [hbps_pkg::RAMP_W-1:0] to_ramp(
      input logic [hbps_pkg::SS_W-1:0] lvl);
      logic [hbps_pkg::SS_W+hbps_pkg::RAMP_W-1:0] p;
      p = lvl * hbps_pkg::OSC_LAST;
      to_ramp = p[hbps_pkg::SS_W+hbps_pkg::RAMP_W-1:hbps_pkg::SS_W];
   endfunction

   // ------------------------------------------------------------
   // Oscillator
   // ------------------------------------------------------------
   hbps_osc i_hbps_osc
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .run(run),
      .ramp_r(ramp),
      .high_phase_r(high_phase),
      .cycle_end(cycle_end)
   );

   // ------------------------------------------------------------
   // Fault qualification
   // ------------------------------------------------------------
   assign supply_ok = supply_good && input_detect_level;
   assign hard_fault = !supply_ok || overtemp || severe_overcurrent;
   assign restart_ok = (ss_r <= hbps_pkg::SS_RESTART_LVL)
      && supply_ok && !overtemp;
   assign run = (state_r == hbps_pkg::HBPS_SOFT)
      || (state_r == hbps_pkg::HBPS_RUN)
      || (state_r == hbps_pkg::HBPS_MILD);
   assign cycle_start = cycle_end && high_phase;

   // Overcurrent seen in a low cycle, held until the next low cycle
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         oc_hit_r <= 1'b0;
      else if (cycle_start || !run)
         oc_hit_r <= 1'b0;
      else if (oc_armed_r && moderate_overcurrent && !high_phase)
         oc_hit_r <= 1'b1;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         oc_latched_r <= 1'b0;
      else if (!run)
         oc_latched_r <= 1'b0;
      else if (oc_hit_r)
         oc_latched_r <= 1'b1;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         oc_armed_r <= 1'b0;
      else if (ss_done_r)
         oc_armed_r <= 1'b1;
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         hbps_pkg::HBPS_OFF:
            if (supply_ok && !overtemp && !severe_overcurrent)
               state_nxt = hbps_pkg::HBPS_SOFT;
         hbps_pkg::HBPS_SOFT:
            if (hard_fault)
               state_nxt = hbps_pkg::HBPS_HICCUP;
            else if (ss_r == hbps_pkg::SS_MAX)
               state_nxt = hbps_pkg::HBPS_RUN;
         hbps_pkg::HBPS_RUN:
            if (hard_fault)
               state_nxt = hbps_pkg::HBPS_HICCUP;
            else if (ss_r < hbps_pkg::SS_DUTY42_LVL)
               state_nxt = hbps_pkg::HBPS_HICCUP;
            else if (mild_fault)
               state_nxt = hbps_pkg::HBPS_MILD;
         hbps_pkg::HBPS_MILD:
            if (hard_fault || ss_r < hbps_pkg::SS_DUTY42_LVL)
               state_nxt = hbps_pkg::HBPS_HICCUP;
            else if (!mild_fault)
               state_nxt = hbps_pkg::HBPS_SOFT;
         hbps_pkg::HBPS_HICCUP:
            if (ss_r <= hbps_pkg::SS_RESTART_LVL)
               state_nxt = hbps_pkg::HBPS_WAIT;
         hbps_pkg::HBPS_WAIT:
            if (restart_ok && !severe_overcurrent)
               state_nxt = hbps_pkg::HBPS_SOFT;
         default:
            state_nxt = hbps_pkg::HBPS_OFF;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         state_r <= hbps_pkg::HBPS_OFF;
      else
         state_r <= state_nxt;
   end

   // Soft start counts as complete on first arrival at the top
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         ss_done_r <= 1'b0;
      else
         ss_done_r <= (state_r == hbps_pkg::HBPS_SOFT)
            && (state_nxt == hbps_pkg::HBPS_RUN);
   end

   // ------------------------------------------------------------
   // Soft-start level, stepped once per oscillator cycle, every mclk in hiccup
   // ------------------------------------------------------------
   always_comb
   begin
      ss_nxt = ss_r;
      unique case (state_r)
         hbps_pkg::HBPS_OFF:
            ss_nxt = hbps_pkg::SS_RESET;
         hbps_pkg::HBPS_SOFT:
            if (cycle_end)
               ss_nxt = sat_add(ss_r, step_charge);
         hbps_pkg::HBPS_RUN:
            if (cycle_end && oc_hit_r)
               ss_nxt = sat_sub(ss_r, step_fast_dis);
         hbps_pkg::HBPS_MILD:
            if (cycle_end)
               ss_nxt = (ss_r > mild_floor_r)
                  ? sat_sub(ss_r, step_fast_dis)
                  : sat_sub(ss_r, step_slow_dis);
         hbps_pkg::HBPS_HICCUP:
            ss_nxt = sat_sub(ss_r, step_slow_dis);
         hbps_pkg::HBPS_WAIT:
            ss_nxt = ss_r;
         default:
            ss_nxt = hbps_pkg::SS_RESET;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         ss_r <= hbps_pkg::SS_RESET;
      else
         ss_r <= ss_nxt;
   end

   // Floor captured as 0.85 of the level on entry to a mild fault
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         mild_floor_r <= hbps_pkg::SS_RESET;
      else if (state_r != hbps_pkg::HBPS_MILD)
         mild_floor_r <= 12'((32'(ss_r) * hbps_pkg::MILD_NUM)
            / hbps_pkg::MILD_DEN);
   end

   // ------------------------------------------------------------
   // Pulse width
   // ------------------------------------------------------------
   // Feed-forward: a higher ramp peak shortens the dead-band pulse
   // Peak of zero stands for full scale; quotient clipped to the ramp
   always_comb
   begin
      db_quot = (16'(dead_band_reference) * 16'(hbps_pkg::OSC_LAST))
         / ((ff_peak == '0) ? 16'h00ff : 16'(ff_peak));
      db_scaled = (db_quot > 16'(hbps_pkg::OSC_LAST))
         ? hbps_pkg::OSC_LAST : db_quot[hbps_pkg::RAMP_W-1:0];
   end

   assign ss_ramp = to_ramp(ss_r);
   assign cap42 = to_ramp(hbps_pkg::SS_DUTY42_LVL);

   always_comb
   begin
      limit = (ss_ramp < db_scaled) ? ss_ramp : db_scaled;
      if (oc_latched_r && limit > cap42)
         limit = cap42;
   end

   assign pulse_on = run && (ramp < limit);

   // Registered drives; hard fault clears them through the register on the next edge
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         low_q_r <= 1'b0;
      else
         low_q_r <= pulse_on && !high_phase && !hard_fault;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         high_q_r <= 1'b0;
      else
         high_q_r <= pulse_on && high_phase && low_seen_r
            && !hard_fault;
   end

   // First low cycle opens at zero width, so high side waits for a low pulse
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         low_seen_r <= 1'b0;
      else if (!run)
         low_seen_r <= 1'b0;
      else if (low_q_r)
         low_seen_r <= 1'b1;
   end

   // Severe fault cuts the drive without waiting for a clock
   assign low_side_drive = low_q_r && !severe_overcurrent;
   assign high_side_drive = high_q_r && !severe_overcurrent;

   // ------------------------------------------------------------
   // Status
   // ------------------------------------------------------------
   assign seq_state = state_r;
   assign ss_level = ss_r;
   assign ss_done = ss_done_r;
   assign oc_armed = oc_armed_r;
   assign hiccup_active = (state_r == hbps_pkg::HBPS_HICCUP)
      || (state_r == hbps_pkg::HBPS_WAIT);
endmodule
`default_nettype wire

// ---- hbps_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbps_top_asserts
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Inputs watched
   input wire logic supply_good,
   input wire logic input_detect_level,
   input wire logic moderate_overcurrent,
   input wire logic severe_overcurrent,
   input wire logic overtemp,
   // Outputs watched
   input wire logic low_side_drive,
   input wire logic high_side_drive,
   input wire logic [2:0] seq_state,
   input wire logic [hbps_pkg::SS_W-1:0] ss_level,
   input wire logic ss_done,
   input wire logic oc_armed,
   input wire logic hiccup_active
);
   // ----------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   logic drv;
   logic seen_low_r;
   assign drv = low_side_drive | high_side_drive;
   // Sticky until reset, so restarts need no tracking
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         seen_low_r <= 1'b0;
      else if (low_side_drive)
         seen_low_r <= 1'b1;
   end
   // ----------------------------------------------------------
   // Properties
   // ----------------------------------------------------------
   chk_no_overlap: assert property (!(low_side_drive && high_side_drive))
      else $error("both drives high together");
   chk_low_first: assert property ($rose(high_side_drive) |-> seen_low_r)
      else $error("high drive before any low drive");
   chk_soc_cut: assert property (severe_overcurrent |-> !drv)
      else $error("drive high during severe overcurrent");
   chk_soc_hiccup: assert property (severe_overcurrent && seq_state inside
      {hbps_pkg::HBPS_SOFT, hbps_pkg::HBPS_RUN, hbps_pkg::HBPS_MILD}
      |=> seq_state == hbps_pkg::HBPS_HICCUP)
      else $error("no hiccup after severe overcurrent");
   chk_supply_loss: assert property (!supply_good |=> !drv)
      else $error("switching with supply low");
   chk_hiccup_quiet: assert property (hiccup_active && $past(hiccup_active)
      |-> !drv)
      else $error("drive high in hiccup");
   chk_detect_static: assert property (!input_detect_level ##1
      !input_detect_level |-> !drv)
      else $error("switching with input detect low");
   chk_done_full: assert property (ss_done |-> ss_level == hbps_pkg::SS_MAX
      && seq_state == hbps_pkg::HBPS_RUN)
      else $error("soft start done below full level");
   chk_oc_ignored: assert property (!oc_armed && moderate_overcurrent
      && supply_good && !overtemp && !severe_overcurrent && input_detect_level
      && seq_state == hbps_pkg::HBPS_SOFT |=> seq_state != hbps_pkg::HBPS_HICCUP)
      else $error("moderate overcurrent acted on before arming");
   chk_restart_gate: assert property (seq_state == hbps_pkg::HBPS_SOFT &&
      $past(seq_state) == hbps_pkg::HBPS_WAIT |-> $past(supply_good) &&
      !$past(overtemp) && $past(ss_level) <= hbps_pkg::SS_RESTART_LVL)
      else $error("restart without restart conditions");
   chk_ss_rise: assert property (seq_state == hbps_pkg::HBPS_SOFT &&
      $past(seq_state) == hbps_pkg::HBPS_SOFT |-> ss_level >= $past(ss_level))
      else $error("soft-start level fell during soft start");
endmodule
bind hbps_top hbps_top_asserts i_hbps_top_asserts (.mclk, .reset_n,
   .supply_good, .input_detect_level, .moderate_overcurrent,
   .severe_overcurrent, .overtemp, .low_side_drive, .high_side_drive,
   .seq_state, .ss_level, .ss_done, .oc_armed, .hiccup_active);
`default_nettype wire

// ---- hbps_switch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbps_switch_model
(
   // Clock
   input wire logic mclk,
   // Gate drives
   input wire logic low_side_drive,
   input wire logic high_side_drive,
   // Load: 0 normal, 1 heavy, 2 shorted
   input wire logic [1:0] load_mode,
   // Sense comparator results
   output logic moderate_overcurrent,
   output logic severe_overcurrent
);
   // ----------------------------------------------------------
   // Sense resistor under the low-side switch
   // ----------------------------------------------------------
   // Registered: keeps the comparator out of the drive cut loop
   always_ff @(posedge mclk)
   begin
      moderate_overcurrent <= low_side_drive && load_mode == 2'h1;
      severe_overcurrent <= low_side_drive &&
         (load_mode == 2'h2 || high_side_drive);
   end
endmodule
`default_nettype wire

// ---- hbps_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbps_top_tb;
   logic mclk, reset_n, supply_good, input_detect_level, overtemp, mild_fault;
   logic moderate_overcurrent, severe_overcurrent;
   logic low_side_drive, high_side_drive, ss_done, oc_armed, hiccup_active;
   logic [1:0] load_mode;
   logic [2:0] seq_state;
   logic [hbps_pkg::SS_W-1:0] ss_level, step_charge, step_fast_dis;
   logic [hbps_pkg::SS_W-1:0] step_slow_dis;
   logic [hbps_pkg::RAMP_W-1:0] dead_band_reference, ff_peak;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   int r;
   int on;
   hbps_top i_hbps_top (.mclk, .reset_n, .supply_good, .input_detect_level,
      .moderate_overcurrent, .severe_overcurrent, .overtemp, .mild_fault,
      .dead_band_reference, .ff_peak, .step_charge, .step_fast_dis,
      .step_slow_dis, .low_side_drive, .high_side_drive, .seq_state,
      .ss_level, .ss_done, .oc_armed, .hiccup_active);
   hbps_switch_model i_hbps_switch_model (.mclk, .low_side_drive,
      .high_side_drive, .load_mode, .moderate_overcurrent,
      .severe_overcurrent);
   // ----------------------------------------------------------
   // Clock, timeout and shared tasks
   // ----------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Whole run needs about 36k cycles
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         n_fail++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_st(input logic [2:0] st, input int lim);
      int i;
      i = 0;
      while (seq_state !== st && i < lim)
      begin
         @(negedge mclk);
         i++;
      end
      chk("seq_state", 32'(st), 32'(seq_state));
   endtask
   // Counts low-side pulse starts and cycles with any drive on
   task automatic watch(input int n, output int rises, output int act);
      logic prev;
      rises = 0;
      act = 0;
      prev = low_side_drive;
      repeat (n)
      begin
         @(negedge mclk);
         if (low_side_drive === 1'b1 && prev !== 1'b1)
            rises++;
         if (low_side_drive !== 1'b0 || high_side_drive !== 1'b0)
            act++;
         prev = low_side_drive;
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   // Heavy load throughout soft start must not trip a hiccup
   task automatic t_start;
      int i;
      load_mode = 2'h1;
      supply_good = 1'b1;
      input_detect_level = 1'b1;
      wait_st(hbps_pkg::HBPS_SOFT, 4);
      i = 0;
      while (low_side_drive !== 1'b1 && high_side_drive !== 1'b1 && i < 600)
      begin
         @(negedge mclk);
         i++;
      end
      chk("first_low", 32'h1, 32'(low_side_drive));
      while (ss_done !== 1'b1 && i < 6000)
      begin
         @(negedge mclk);
         i++;
      end
      load_mode = 2'h0;
      chk("ss_full", 32'(hbps_pkg::SS_MAX), 32'(ss_level));
      chk("state_run", 32'(hbps_pkg::HBPS_RUN), 32'(seq_state));
      watch(2000, r, on);
      chk("low_pulses", 32'h4, 32'(r));
      chk("ss_hold", 32'(hbps_pkg::SS_MAX), 32'(ss_level));
      chk("oc_armed", 32'h1, 32'(oc_armed));
   endtask
   // Dead-band width at full-scale peak, then at a lower peak
   task automatic t_ff;
      int w0;
      int e;
      watch(500, r, on);
      w0 = on;
      e = 2 * (int'(dead_band_reference) * hbps_pkg::OSC_LAST / 255);
      chk("width_full", 32'(e), 32'(on));
      ff_peak = 8'hc0;
      watch(500, r, on);
      watch(500, r, on);
      e = 2 * (int'(dead_band_reference) * hbps_pkg::OSC_LAST
         / int'(ff_peak));
      chk("width_ff", 32'(e), 32'(on));
      chk("ff_wider", 32'h1, 32'(on > w0));
   endtask
   // Cap at the 42 percent point while the level is still high
   task automatic t_moc;
      int e;
      load_mode = 2'h1;
      e = 2 * (int'(hbps_pkg::SS_DUTY42_LVL) * hbps_pkg::OSC_LAST
         / (1 << hbps_pkg::SS_W));
      watch(1000, r, on);
      watch(500, r, on);
      chk("oc_cap", 32'(e), 32'(on));
      wait_st(hbps_pkg::HBPS_HICCUP, 9000);
      chk("below42", 32'h1, 32'(ss_level < hbps_pkg::SS_DUTY42_LVL));
      load_mode = 2'h0;
      wait_st(hbps_pkg::HBPS_WAIT, 3000);
      chk("restart", 32'h1, 32'(ss_level <= hbps_pkg::SS_RESTART_LVL));
      wait_st(hbps_pkg::HBPS_SOFT, 50);
   endtask
   task automatic t_soc;
      load_mode = 2'h2;
      wait_st(hbps_pkg::HBPS_HICCUP, 1200);
      load_mode = 2'h0;
      wait_st(hbps_pkg::HBPS_WAIT, 3000);
      wait_st(hbps_pkg::HBPS_SOFT, 50);
      wait_st(hbps_pkg::HBPS_RUN, 6000);
   endtask
   // Hard faults: supply loss then overtemperature
   task automatic t_hard(input bit uv);
      if (uv)
         supply_good = 1'b0;
      else
         overtemp = 1'b1;
      @(negedge mclk);
      chk("drives_off", 32'h0, 32'({low_side_drive, high_side_drive}));
      chk("hiccup", 32'h1, 32'(hiccup_active));
      wait_st(hbps_pkg::HBPS_WAIT, 6000);
      repeat (300) @(negedge mclk);
      chk("held", 32'(hbps_pkg::HBPS_WAIT), 32'(seq_state));
      supply_good = 1'b1;
      overtemp = 1'b0;
      wait_st(hbps_pkg::HBPS_SOFT, 5);
   endtask
   task automatic t_mild;
      logic [31:0] hi;
      hi = 32'(hbps_pkg::SS_MAX) * hbps_pkg::MILD_NUM / hbps_pkg::MILD_DEN;
      mild_fault = 1'b1;
      wait_st(hbps_pkg::HBPS_MILD, 5);
      repeat (1100) @(negedge mclk);
      chk("mild_lvl", 32'h1,
         32'(ss_level <= hi && ss_level >= hi - 32'(step_fast_dis)));
      mild_fault = 1'b0;
      wait_st(hbps_pkg::HBPS_SOFT, 600);
      wait_st(hbps_pkg::HBPS_RUN, 6000);
   endtask
   task automatic t_detect;
      input_detect_level = 1'b0;
      repeat (2) @(negedge mclk);
      watch(600, r, on);
      chk("static", 32'h0, 32'(on));
      input_detect_level = 1'b1;
      watch(9000, r, on);
      chk("resumed", 32'h1, 32'(r > 0));
   endtask
   initial
   begin
      reset_n = 1'b0;
      {supply_good, input_detect_level, overtemp, mild_fault} = 4'h0;
      load_mode = 2'h0;
      step_charge = 12'h100;
      step_fast_dis = 12'h100;
      step_slow_dis = hbps_pkg::STEP_SLOW_DIS_DEF;
      dead_band_reference = 8'h60;
      ff_peak = 8'h00;
      repeat (8) @(negedge mclk);
      reset_n = 1'b1;
      t_start();
      t_ff();
      t_moc();
      t_soc();
      t_hard(1'b1);
      t_hard(1'b0);
      wait_st(hbps_pkg::HBPS_RUN, 6000);
      t_mild();
      t_detect();
      results();
   end
endmodule
`default_nettype wire
